// *** src/rtcsl_core.sv ***
// Control and status logic of the real-time clock: timebase, periodic interrupt, flags
//
// Behaviour
// R1: Sub-clock output follows crystal if either disable bit is 0 and pin high.
// R2: Both clock-disable bits: 0 enables, 1 disables, reset to 0.
// R3: Test bit: 0 normal, 1 factory test; host keeps it 0.
// R4: Selector 000 holds output high, 001 low, 010/011 give 2 Hz/1 Hz pulses.
// R5: Level codes assert low per second, minute, hour, month; fall with seconds increment.
// R6: Pulse mode: seconds increment about 46 us after pulse falling edge.
// R7: Pulse mode: seconds write clears sub-second divider and drives output low.
// R8: Level mode: output may glitch after selector write; host checks periodic flag.
// R9: Adjustment shifts one second by up to 3.784 ms every 20 or 60 s.
// R10: Oscillator-mode bit selects low current; without feature it is plain storage.
// R11: Supply-low flag sets below threshold, then monitor stops and flag holds.
// R12: Writing 0 clears supply-low flag and restarts monitor; 1 does nothing.
// R13: Oscillation-halt flag sets on halt, holds until 0 written.
// R14: Power-up flag sets when supply rises from zero and stays set.
// R15: While power-up flag set, adjust and control bits clear, interrupt released.
// R16: Writing 0 clears power-up flag; writing 1 does nothing.
// R17: Periodic flag reads 1 while periodic output is low, else 0.
// R18: Level mode: writing 0 clears periodic flag and releases output until next event.
// R19: A set event in the same cycle as a clear wins over the clear; for the supply-low flag the code lets the clear win.
`timescale 1ns/100ps
module rtcsl_core #(
  parameter bit HAS_LOW_CURRENT = 1'b1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic xtal_clk,
  input wire logic clock_out_control_pin,
  input wire logic supply_below_threshold,
  input wire logic osc_halt_detect,
  input wire rtcsl_pkg::rtcsl_wr_t reg_wr,
  input wire logic [3:0] reg_rd_addr,
  output logic [7:0] reg_rd_data,
  input wire rtcsl_pkg::rtcsl_time_t time_status,
  output logic seconds_increment,
  output logic interrupt_out_a_n,
  output logic sub_clock_output,
  output logic low_current_osc_select,
  output logic test_mode
);

  typedef struct packed {
    logic [1:0] xtal_sync;
    logic [1:0] pin_sync;
    logic [1:0] vlow_sync;
    logic [1:0] halt_sync;
    logic xtal_prev;
    logic [15:0] div;
    logic [5:0] adj_secs;
    logic [10:0] dly;
    logic dly_busy;
    logic [7:0] cr1;
    logic [7:0] adj;
    logic low_current;
    logic supply_low_flag;
    logic osc_halt_flag;
    logic power_up_flag;
    logic clk_dis_a;
    logic periodic_flag;
    logic sub_clk;
    logic int_n;
    logic sec_inc;
    logic [7:0] rd_data;
  } rtcsl_state_t;

  rtcsl_state_t s_q;
  rtcsl_state_t s_d;

  logic xtal_rise;
  logic [15:0] top;
  logic wrap;
  logic [2:0] sel;
  logic pulse_mode;
  logic level_mode;
  logic level_event;
  logic wr_cr2;
  logic [5:0] adj_mag;
  logic [15:0] adj_step;

  always_comb begin
    s_d = s_q;
    // Sampled inputs from outside the clock domain, two stages each
    s_d.xtal_sync = {s_q.xtal_sync[0], xtal_clk};
    s_d.pin_sync = {s_q.pin_sync[0], clock_out_control_pin};
    s_d.vlow_sync = {s_q.vlow_sync[0], supply_below_threshold};
    s_d.halt_sync = {s_q.halt_sync[0], osc_halt_detect};
    s_d.xtal_prev = s_q.xtal_sync[1];
    xtal_rise = s_q.xtal_sync[1] & ~s_q.xtal_prev;

    sel = s_q.cr1[rtcsl_pkg::CR1_SEL_LSB +: 3];
    pulse_mode = (sel == rtcsl_pkg::SEL_PULSE_2HZ) || (sel == rtcsl_pkg::SEL_PULSE_1HZ);
    level_mode = sel[2];
    wr_cr2 = reg_wr.en && (reg_wr.addr == rtcsl_pkg::OFS_STATUS_CONTROL_TWO);

    // Adjusted second: length changes by two periods per step above one
    adj_mag = s_q.adj[5:0];
    adj_step = (adj_mag > 6'h01) ? {9'h000, adj_mag - 6'h01, 1'b0} : 16'h0000; // R9
    top = rtcsl_pkg::DIV_TOP;
    if (s_q.adj_secs == 6'h00) begin
      top = s_q.adj[rtcsl_pkg::ADJ_SIGN] ? rtcsl_pkg::DIV_TOP - adj_step
                                         : rtcsl_pkg::DIV_TOP + adj_step; // R9
    end

    // Sub-second divider on crystal edges
    wrap = 1'b0;
    if (xtal_rise) begin
      if (s_q.div >= top) begin
        s_d.div = 16'h0000;
        wrap = 1'b1;
      end else begin
        s_d.div = s_q.div + 16'h0001;
      end
    end
    if (wrap) begin
      if (s_q.adj_secs == 6'h00) begin
        s_d.adj_secs = s_q.adj[rtcsl_pkg::ADJ_DEV] ? rtcsl_pkg::ADJ_PERIOD_LONG
                                                 : rtcsl_pkg::ADJ_PERIOD_SHORT; // R9
      end else begin
        s_d.adj_secs = s_q.adj_secs - 6'h01;
      end
    end

    // Seconds increment: delayed after the falling pulse edge in pulse mode
    s_d.sec_inc = 1'b0;
    if (wrap && pulse_mode) begin
      s_d.dly_busy = 1'b1; // R6
      s_d.dly = rtcsl_pkg::INC_DELAY;
    end else if (wrap) begin
      s_d.sec_inc = 1'b1; // R5
    end else if (s_q.dly_busy) begin
      s_d.dly = s_q.dly - 11'h001;
      if (s_q.dly == 11'h001) begin
        s_d.dly_busy = 1'b0;
        s_d.sec_inc = 1'b1; // R6
      end
    end

    // Writing the seconds counter restarts the second; low phase starts at zero
    if (reg_wr.en && reg_wr.addr == rtcsl_pkg::OFS_SECONDS) begin
      s_d.div = 16'h0000; // R7
      s_d.dly_busy = 1'b0;
    end

    // Register writes
    if (reg_wr.en && reg_wr.addr == rtcsl_pkg::OFS_OSC_ADJUST) begin
      s_d.adj = reg_wr.data;
    end
    if (reg_wr.en && reg_wr.addr == rtcsl_pkg::OFS_CONTROL_ONE) begin
      s_d.cr1 = reg_wr.data; // R2 R3
    end
    if (wr_cr2) begin
      s_d.low_current = reg_wr.data[rtcsl_pkg::CR2_LOW_CUR]; // R10
      s_d.clk_dis_a = reg_wr.data[rtcsl_pkg::CR2_CLK_DIS_A]; // R2
      if (!reg_wr.data[rtcsl_pkg::CR2_SUPPLY_LOW]) begin
        s_d.supply_low_flag = 1'b0; // R12
      end
      if (!reg_wr.data[rtcsl_pkg::CR2_OSC_HALT]) begin
        s_d.osc_halt_flag = 1'b0; // R13
      end
      if (!reg_wr.data[rtcsl_pkg::CR2_POWER_UP]) begin
        s_d.power_up_flag = 1'b0; // R16
      end
      // Clearing in pulse or fixed modes is ignored: the flag mirrors the pin there
      if (!reg_wr.data[rtcsl_pkg::CR2_PERIODIC] && level_mode) begin
        s_d.periodic_flag = 1'b0; // R18
      end
    end

    // Monitor only runs while the flag is clear; once set it simply holds
    if (!s_q.supply_low_flag && s_q.vlow_sync[1]) begin
      s_d.supply_low_flag = 1'b1; // R11 R19
    end
    if (s_q.halt_sync[1]) begin
      s_d.osc_halt_flag = 1'b1; // R13 R19
    end

    // Level-mode events, taken at the seconds roll-over
    unique case (sel)
      rtcsl_pkg::SEL_LVL_SECOND: level_event = 1'b1;
      rtcsl_pkg::SEL_LVL_MINUTE: level_event = time_status.sec_last;
      rtcsl_pkg::SEL_LVL_HOUR: level_event = time_status.sec_last & time_status.min_last;
      rtcsl_pkg::SEL_LVL_MONTH: level_event = time_status.sec_last & time_status.min_last &
                                              time_status.hour_last & time_status.month_last;
      default: level_event = 1'b0;
    endcase
    // A selector write can leave a stale flag; reading it back tells a real event apart
    if (wrap && level_mode && level_event) begin
      s_d.periodic_flag = 1'b1; // R5 R8 R19
    end

    // Power-up flag forces the control bits clear every cycle it stands
    if (s_q.power_up_flag) begin
      s_d.adj = 8'h00; // R15
      s_d.cr1 = 8'h00;
      s_d.low_current = 1'b0;
      s_d.clk_dis_a = 1'b0;
      s_d.periodic_flag = 1'b0;
    end

    // Periodic output, computed from the next state so flag and pin agree
    s_d.int_n = 1'b1;
    if (!s_q.power_up_flag) begin
      unique case (sel)
        rtcsl_pkg::SEL_OFF: s_d.int_n = 1'b1; // R4
        rtcsl_pkg::SEL_FIXED_LOW: s_d.int_n = 1'b0;
        rtcsl_pkg::SEL_PULSE_2HZ: s_d.int_n = s_d.div[13];
        rtcsl_pkg::SEL_PULSE_1HZ: s_d.int_n = (s_d.div >= rtcsl_pkg::DIV_HALF);
        default: s_d.int_n = ~s_d.periodic_flag; // R18
      endcase
    end
    if (!level_mode || s_q.power_up_flag) begin
      s_d.periodic_flag = ~s_d.int_n; // R17
    end

    // Sub-clock gating
    s_d.sub_clk = s_q.xtal_sync[1] & s_q.pin_sync[1] &
                  ~(s_q.clk_dis_a & s_q.cr1[rtcsl_pkg::CR1_CLK_DIS_B]); // R1

    // Read path; unmapped offsets here read as zero
    unique case (reg_rd_addr)
      rtcsl_pkg::OFS_OSC_ADJUST: s_d.rd_data = s_q.adj;
      rtcsl_pkg::OFS_CONTROL_ONE: s_d.rd_data = s_q.cr1;
      rtcsl_pkg::OFS_STATUS_CONTROL_TWO: s_d.rd_data = {s_q.low_current, s_q.supply_low_flag,
        s_q.osc_halt_flag, s_q.power_up_flag, s_q.clk_dis_a, s_q.periodic_flag, 2'b00}; // R17
      default: s_d.rd_data = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
      s_q.cr1 <= rtcsl_pkg::RST_CONTROL_ONE; // R2
      s_q.adj <= rtcsl_pkg::RST_OSC_ADJUST;
      s_q.supply_low_flag <= rtcsl_pkg::RST_STATUS_CONTROL_TWO[rtcsl_pkg::CR2_SUPPLY_LOW];
      s_q.osc_halt_flag <= rtcsl_pkg::RST_STATUS_CONTROL_TWO[rtcsl_pkg::CR2_OSC_HALT];
      s_q.power_up_flag <= rtcsl_pkg::RST_STATUS_CONTROL_TWO[rtcsl_pkg::CR2_POWER_UP]; // R14
      s_q.int_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign reg_rd_data = s_q.rd_data;
  assign seconds_increment = s_q.sec_inc;
  assign interrupt_out_a_n = s_q.int_n;
  assign sub_clock_output = s_q.sub_clk;
  assign low_current_osc_select = s_q.low_current & HAS_LOW_CURRENT; // R10
  assign test_mode = s_q.cr1[rtcsl_pkg::CR1_TEST]; // R3

endmodule

// *** src/rtcsl_pkg.sv ***
// Package: constants and carrier types of the real-time clock control and status logic
package rtcsl_pkg;
  // Register offsets on the serial register port
  localparam logic [3:0] OFS_SECONDS = 4'h0;
  localparam logic [3:0] OFS_OSC_ADJUST = 4'h7;
  localparam logic [3:0] OFS_CONTROL_ONE = 4'he;
  localparam logic [3:0] OFS_STATUS_CONTROL_TWO = 4'hf;
  // Control register one fields
  localparam int CR1_CLK_DIS_B = 4;
  localparam int CR1_TEST = 3;
  localparam int CR1_SEL_LSB = 0;
  // Status/control register two fields
  localparam int CR2_LOW_CUR = 7;
  localparam int CR2_SUPPLY_LOW = 6;
  localparam int CR2_OSC_HALT = 5;
  localparam int CR2_POWER_UP = 4;
  localparam int CR2_CLK_DIS_A = 3;
  localparam int CR2_PERIODIC = 2;
  // Oscillation adjustment fields
  localparam int ADJ_DEV = 7;
  localparam int ADJ_SIGN = 6;
  // Reset values
  localparam logic [7:0] RST_CONTROL_ONE = 8'h00;
  localparam logic [7:0] RST_STATUS_CONTROL_TWO = 8'h70;
  localparam logic [7:0] RST_OSC_ADJUST = 8'h00;
  // Periodic selector codes
  localparam logic [2:0] SEL_OFF = 3'h0;
  localparam logic [2:0] SEL_FIXED_LOW = 3'h1;
  localparam logic [2:0] SEL_PULSE_2HZ = 3'h2;
  localparam logic [2:0] SEL_PULSE_1HZ = 3'h3;
  localparam logic [2:0] SEL_LVL_SECOND = 3'h4;
  localparam logic [2:0] SEL_LVL_MINUTE = 3'h5;
  localparam logic [2:0] SEL_LVL_HOUR = 3'h6;
  localparam logic [2:0] SEL_LVL_MONTH = 3'h7;
  // Timebase: one second is 32768 crystal periods
  localparam logic [15:0] DIV_TOP = 16'h7fff;
  localparam logic [15:0] DIV_HALF = 16'h4000;
  localparam logic [5:0] ADJ_PERIOD_SHORT = 6'h13;
  localparam logic [5:0] ADJ_PERIOD_LONG = 6'h3b;
  // Seconds increment lags the pulse falling edge
  localparam int CLK_PERIOD_NS = 25;
  localparam int INC_DELAY_NS = 46000;
  localparam int INC_DELAY_CYC = INC_DELAY_NS / CLK_PERIOD_NS;
  localparam logic [10:0] INC_DELAY = 11'(INC_DELAY_CYC);

  typedef struct packed {
    logic en;
    logic [3:0] addr;
    logic [7:0] data;
  } rtcsl_wr_t;

  // Roll-over status from the time counters, true when the next increment wraps
  typedef struct packed {
    logic sec_last;
    logic min_last;
    logic hour_last;
    logic month_last;
  } rtcsl_time_t;
endpackage

// *** tb/rtcsl_core_chk.sv ***
// Port checker for the control and status logic
`timescale 1ns/100ps
module rtcsl_core_chk #(
  parameter bit HAS_LOW_CURRENT = 1'b1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clock_out_control_pin,
  input wire rtcsl_pkg::rtcsl_wr_t reg_wr,
  input wire logic [3:0] reg_rd_addr,
  input wire logic [7:0] reg_rd_data,
  input wire logic seconds_increment,
  input wire logic interrupt_out_a_n,
  input wire logic sub_clock_output,
  input wire logic low_current_osc_select,
  input wire logic test_mode
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////
  sequence s_rd_f;
    reg_rd_addr == 4'hf;
  endsequence
  sequence s_clr_pon;
    reg_wr.en && reg_wr.addr == 4'hf && !reg_wr.data[4];
  endsequence
  property p_subclk_off;
    (!clock_out_control_pin) [*6] |-> !sub_clock_output;
  endproperty
  property p_pon_outs;
    $fell(rst) |-> interrupt_out_a_n && !test_mode && !low_current_osc_select;
  endproperty
  property p_inc_pulse;
    seconds_increment |=> !seconds_increment [*8];
  endproperty
  // Stability guard keeps the check independent of the output register lag
  property p_test_rd;
    reg_rd_addr == 4'he ##1 $stable(test_mode) |-> reg_rd_data[3] == test_mode;
  endproperty
  property p_eco_rd;
    s_rd_f ##1 $stable(low_current_osc_select)
      |-> (reg_rd_data[7] & HAS_LOW_CURRENT) == low_current_osc_select;
  endproperty
  property p_flag_rd;
    s_rd_f ##1 $stable(interrupt_out_a_n) |-> reg_rd_data[2] == !interrupt_out_a_n;
  endproperty
  property p_sticky;
    (reg_rd_addr == 4'hf && !reg_wr.en) ##1 s_rd_f
      |=> ($past(reg_rd_data[6:4]) & ~reg_rd_data[6:4]) == 3'h0;
  endproperty
  property p_pon_clr;
    s_clr_pon ##2 s_rd_f |=> !reg_rd_data[4];
  endproperty
  a_subclk_off: assert property (p_subclk_off) else $error("sub clock with pin low");
  a_pon_outs: assert property (p_pon_outs) else $error("outputs not idle after reset");
  a_inc_pulse: assert property (p_inc_pulse) else $error("increment pulse too long");
  a_test_rd: assert property (p_test_rd) else $error("test output differs");
  a_eco_rd: assert property (p_eco_rd) else $error("low current output differs");
  a_flag_rd: assert property (p_flag_rd) else $error("periodic flag differs");
  a_sticky: assert property (p_sticky) else $error("sticky flag fell");
  a_pon_clr: assert property (p_pon_clr) else $error("power up flag not cleared");
endmodule

// *** tb/rtcsl_host.sv ***
// Host model driving the register port
`timescale 1ns/100ps
module rtcsl_host (
  input wire logic clk,
  output rtcsl_pkg::rtcsl_wr_t reg_wr,
  output logic [3:0] reg_rd_addr,
  output logic rd_go
);
  initial begin
    reg_wr = '0;
    reg_rd_addr = 4'h1;
    rd_go = 1'b0;
  end
  ////////////////////////////////////////////////////////////
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= '{en: 1'b1, addr: a, data: d};
    @(posedge clk);
    reg_wr.en <= 1'b0;
  endtask
  // Idle address is unmapped so a stray read shows zero
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    reg_rd_addr <= a;
    rd_go <= 1'b1;
    @(posedge clk);
    rd_go <= 1'b0;
    reg_rd_addr <= 4'h1;
  endtask
endmodule

// *** tb/rtcsl_core_test.sv ***
// Self-checking bench for the control and status logic
`timescale 1ns/100ps
module rtcsl_core_test;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic xtal_clk = 1'b0;
  logic clock_out_control_pin = 1'b1;
  logic supply_below_threshold = 1'b0;
  logic osc_halt_detect = 1'b0;
  rtcsl_pkg::rtcsl_time_t time_status = '0;
  rtcsl_pkg::rtcsl_wr_t reg_wr;
  logic [3:0] reg_rd_addr;
  logic rd_go;
  logic go_d = 1'b0;
  logic [7:0] reg_rd_data;
  logic seconds_increment, interrupt_out_a_n, sub_clock_output, low_current_osc_select, test_mode;
  logic [7:0] exp_q[$];
  logic [31:0] lfsr_q = 32'hd7fc204c;
  int err_count = 0;
  int samples_checked = 0;
  always #12.5 clk = ~clk;
  initial begin
    #7;
    forever #100 xtal_clk = ~xtal_clk;
  end
  rtcsl_host host (.clk(clk), .reg_wr(reg_wr), .reg_rd_addr(reg_rd_addr), .rd_go(rd_go));
  rtcsl_core dut (.clk(clk), .rst(rst), .xtal_clk(xtal_clk),
    .clock_out_control_pin(clock_out_control_pin), .supply_below_threshold(supply_below_threshold),
    .osc_halt_detect(osc_halt_detect), .reg_wr(reg_wr), .reg_rd_addr(reg_rd_addr),
    .reg_rd_data(reg_rd_data), .time_status(time_status), .seconds_increment(seconds_increment),
    .interrupt_out_a_n(interrupt_out_a_n), .sub_clock_output(sub_clock_output),
    .low_current_osc_select(low_current_osc_select), .test_mode(test_mode));
  ////////////////////////////////////////////////////////////
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk1(input string n, input logic e, input logic g);
    chk8(n, {7'h00, e}, {7'h00, g});
  endtask
  always @(posedge clk) begin
    if (go_d) chk8("read data", exp_q.pop_front(), reg_rd_data);
    go_d <= rd_go;
  end
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host.rd(a);
  endtask
  task automatic settle;
    repeat (8) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic pulse_in(input bit h);
    @(posedge clk);
    if (h) osc_halt_detect <= 1'b1;
    else supply_below_threshold <= 1'b1;
    settle;
    @(posedge clk);
    osc_halt_detect <= 1'b0;
    supply_below_threshold <= 1'b0;
    settle;
  endtask
  task automatic toggles(input logic e);
    int n = 0;
    logic p;
    settle;
    p = sub_clock_output;
    repeat (200) begin
      @(negedge clk);
      if (sub_clock_output !== p) n++;
      p = sub_clock_output;
    end
    chk1("sub clock", e, n != 0);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (40000) @(posedge clk);
    err_count++;
    stop_test;
  end
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rd(4'hf, 8'h70);
    rd(4'he, 8'h00);
    host.wr(4'he, 8'h08);
    rd(4'he, 8'h00);
    host.wr(4'hf, 8'h00);
    host.wr(4'hf, 8'h74);
    rd(4'hf, 8'h00);
    pulse_in(1'b0);
    rd(4'hf, 8'h40);
    pulse_in(1'b1);
    rd(4'hf, 8'h60);
    host.wr(4'hf, 8'h00);
    rd(4'hf, 8'h00);
    $display("flags test done");
    for (int i = 0; i < 4; i++) begin
      lfsr_q = next_rand(lfsr_q);
      time_status <= lfsr_q[19:16];
      host.wr(4'he, lfsr_q[7:0]);
      host.wr(4'h7, lfsr_q[15:8]);
      rd(4'he, lfsr_q[7:0]);
      rd(4'h7, lfsr_q[15:8]);
      settle;
      chk1("test mode", lfsr_q[3], test_mode);
    end
    // Random selector may leave a pulse or fixed-low mode that sets the periodic flag
    host.wr(4'he, 8'h00);
    host.wr(4'hf, 8'h80);
    rd(4'hf, 8'h80);
    settle;
    chk1("low current", 1'b1, low_current_osc_select);
    host.wr(4'he, 8'h10);
    host.wr(4'hf, 8'h88);
    toggles(1'b0);
    host.wr(4'hf, 8'h80);
    toggles(1'b1);
    clock_out_control_pin <= 1'b0;
    toggles(1'b0);
    clock_out_control_pin <= 1'b1;
    host.wr(4'he, 8'h00);
    host.wr(4'hf, 8'h88);
    toggles(1'b1);
    $display("clock test done");
    chk1("interrupt", 1'b1, interrupt_out_a_n);
    host.wr(4'he, 8'h01);
    settle;
    chk1("interrupt", 1'b0, interrupt_out_a_n);
    rd(4'hf, 8'h8c);
    host.wr(4'he, 8'h03);
    host.wr(4'h0, 8'h00);
    settle;
    chk1("interrupt", 1'b0, interrupt_out_a_n);
    host.wr(4'hf, 8'h88);
    rd(4'hf, 8'h8c);
    host.wr(4'he, 8'h04);
    host.wr(4'hf, 8'h88);
    rd(4'hf, 8'h88);
    settle;
    chk1("interrupt", 1'b1, interrupt_out_a_n);
    $display("interrupt test done");
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(4'hf, 8'h70);
    settle;
    chk1("test mode", 1'b0, test_mode);
    chk1("low current", 1'b0, low_current_osc_select);
    $display("second reset test done");
    repeat (3) @(posedge clk);
    stop_test;
  end
endmodule
bind rtcsl_core rtcsl_core_chk #(.HAS_LOW_CURRENT(HAS_LOW_CURRENT)) chk (.clk(clk), .rst(rst),
  .clock_out_control_pin(clock_out_control_pin), .reg_wr(reg_wr), .reg_rd_addr(reg_rd_addr),
  .reg_rd_data(reg_rd_data), .seconds_increment(seconds_increment),
  .interrupt_out_a_n(interrupt_out_a_n), .sub_clock_output(sub_clock_output),
  .low_current_osc_select(low_current_osc_select), .test_mode(test_mode));
